// ===== rtl/sac_consts.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_CTRL_ADDR 4'h0
`define SAC_RESULT_ADDR 4'h4
`define SAC_CTRL_RESET 8'hfc
`define SAC_RESULT_RESET 8'h00
`define SAC_ANS_HI 7
`define SAC_ANS_LO 6
`define SAC_ADCS_HI 5
`define SAC_ADCS_LO 4
`define SAC_CHS_HI 3
`define SAC_CHS_LO 2
`define SAC_GO_BIT 1
`define SAC_ON_BIT 0
`define SAC_SLEEP_CLK_CHAN 4'hf
`define SAC_ADCS_IOSC 2'h3
`define SAC_DIV16_LAST 4'hf
`define SAC_DIV8_LAST 4'h7
`define SAC_DIV4_LAST 4'h3
`define SAC_IOSC_LAST 2'h3
`define SAC_SAMPLE_LAST 4'h4
`define SAC_TAD_LAST 4'hc
`define SAC_MARKER_INIT 8'h80
`endif

// ===== rtl/sac_pkg.sv
// Types shared by the converter control block
package sac_pkg;
  typedef logic [3:0] sac_addr_t;
  typedef logic [7:0] sac_byte_t;
  typedef logic [1:0] sac_field_t;
  typedef enum logic [0:0] {
    SAC_IDLE = 1'b0,
    SAC_CONV = 1'b1
  } sac_state_t;
endpackage : sac_pkg

// ===== rtl/sac_top.sv
// Successive-approximation converter control, result register and Avalon-MM slave
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top (
  input wire logic clk,
  input wire logic rstn,
  input wire sac_pkg::sac_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_enter,
  input wire logic iosc_clk_in,
  input wire logic cmp_result,
  output logic [2:0] analog_pin_en,
  output sac_pkg::sac_field_t adc_channel,
  output logic adc_power,
  output logic sample_en,
  output sac_pkg::sac_byte_t dac_code
);
  import sac_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic iosc_meta_r;
  logic iosc_sync_r;
  logic iosc_prev_r;
  logic iosc_rise;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_fire;
  sac_byte_t wdata;
  sac_state_t state_r;
  sac_state_t state_nxt;
  sac_byte_t ctrl_r;
  sac_byte_t ctrl_nxt;
  sac_byte_t result_r;
  sac_byte_t result_nxt;
  sac_byte_t marker_r;
  sac_byte_t marker_nxt;
  logic [3:0] tad_r;
  logic [3:0] tad_nxt;
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [1:0] iosc_cnt_r;
  logic [1:0] iosc_cnt_nxt;
  sac_field_t cs_act_r;
  sac_field_t cs_act_nxt;
  sac_field_t chan_act_r;
  sac_field_t chan_act_nxt;
  logic [3:0] div_last;
  logic tad_tick;
  logic [2:0] pins_nxt;
  logic [2:0] pins_r;
  sac_field_t chan_out_nxt;
  sac_field_t chan_out_r;
  logic power_r;
  logic sample_nxt;
  logic sample_r;
  sac_byte_t dac_r;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Comparator and oscillator come from outside this clock domain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
      iosc_meta_r <= 1'b0;
      iosc_sync_r <= 1'b0;
      iosc_prev_r <= 1'b0;
    end else begin
      cmp_meta_r <= cmp_result;
      cmp_sync_r <= cmp_meta_r;
      iosc_meta_r <= iosc_clk_in;
      iosc_sync_r <= iosc_meta_r;
      iosc_prev_r <= iosc_sync_r;
    end
  end

  // Edge taken after the second stage only
  assign iosc_rise = iosc_sync_r & ~iosc_prev_r;

  // ---------------------------------------------------------------
  // Conversion clock divider
  // ---------------------------------------------------------------
  // Terminal count of the system clock divider for the latched select
  always_comb begin
    case (cs_act_r)
      2'h0: div_last = `SAC_DIV16_LAST;
      2'h1: div_last = `SAC_DIV8_LAST;
      2'h2: div_last = `SAC_DIV4_LAST;
      default: div_last = `SAC_DIV4_LAST;
    endcase
  end

  // One pulse per conversion bit period; oscillator mode counts its edges
  always_comb begin
    if (cs_act_r == `SAC_ADCS_IOSC) begin
      tad_tick = iosc_rise && (iosc_cnt_r == `SAC_IOSC_LAST);
    end else begin
      tad_tick = (div_r == div_last);
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // One wait cycle per access; the answer lands on the following edge
  assign ack_nxt = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_fire = avs_write & ack_r & avs_byteenable[0];
  assign wdata = avs_writedata[7:0];

  // Read data captured in the wait cycle; reads change no state
  always_comb begin
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      case (avs_address)
        `SAC_CTRL_ADDR: rdata_nxt = {24'h000000, ctrl_r};
        `SAC_RESULT_ADDR: rdata_nxt = {24'h000000, result_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // ---------------------------------------------------------------
  // Control and conversion sequencer
  // ---------------------------------------------------------------
  // Order: period step, then software write, then sleep, which wins all
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    result_nxt = result_r;
    marker_nxt = marker_r;
    tad_nxt = tad_r;
    // Bit period step while converting
    if (state_r == SAC_CONV && tad_tick) begin
      tad_nxt = tad_r + 4'h1;
      if (tad_r == `SAC_SAMPLE_LAST) begin
        marker_nxt = `SAC_MARKER_INIT;
        result_nxt = `SAC_MARKER_INIT;
      end else if (tad_r > `SAC_SAMPLE_LAST) begin
        // The register itself is the trial code; keep bit if input is above
        result_nxt = (result_r & ~marker_r) | (cmp_sync_r ? marker_r : 8'h00)
                     | (marker_r >> 1);
        marker_nxt = marker_r >> 1;
      end
      if (tad_r == `SAC_TAD_LAST) begin
        state_nxt = SAC_IDLE;
        ctrl_nxt[`SAC_GO_BIT] = 1'b0;
      end
    end
    // Software write; result register has no write path
    if (wr_fire && avs_address == `SAC_CTRL_ADDR) begin
      ctrl_nxt[`SAC_ANS_HI:`SAC_CHS_LO] = wdata[`SAC_ANS_HI:`SAC_CHS_LO];
      ctrl_nxt[`SAC_ON_BIT] = wdata[`SAC_ON_BIT];
      if (state_r == SAC_CONV) begin
        // Abort leaves the partial result and the marker in place
        if (!wdata[`SAC_GO_BIT] || !wdata[`SAC_ON_BIT]) begin
          state_nxt = SAC_IDLE;
          ctrl_nxt[`SAC_GO_BIT] = 1'b0;
          result_nxt = result_r;
          marker_nxt = marker_r;
          tad_nxt = tad_r;
        end
      end else if (wdata[`SAC_GO_BIT] && wdata[`SAC_ON_BIT]) begin
        state_nxt = SAC_CONV;
        ctrl_nxt[`SAC_GO_BIT] = 1'b1;
        tad_nxt = 4'h0;
      end else begin
        ctrl_nxt[`SAC_GO_BIT] = 1'b0;
      end
    end
    // Sleep stops everything; analog pin select is left as it is
    if (sleep_enter) begin
      state_nxt = SAC_IDLE;
      ctrl_nxt[`SAC_GO_BIT] = 1'b0;
      ctrl_nxt[`SAC_ON_BIT] = 1'b0;
      ctrl_nxt[`SAC_ADCS_HI:`SAC_CHS_LO] = `SAC_SLEEP_CLK_CHAN;
      result_nxt = result_r;
      marker_nxt = marker_r;
    end
  end

  // Divider restarts at each start and holds at zero when idle
  always_comb begin
    div_nxt = 4'h0;
    iosc_cnt_nxt = 2'h0;
    if (state_r == SAC_CONV && state_nxt == SAC_CONV) begin
      div_nxt = tad_tick ? 4'h0 : div_r + 4'h1;
      iosc_cnt_nxt = iosc_rise ? iosc_cnt_r + 2'h1 : iosc_cnt_r;
    end
  end

  // Clock and channel selects frozen for the length of a conversion
  always_comb begin
    if (state_r == SAC_CONV && state_nxt == SAC_CONV) begin
      cs_act_nxt = cs_act_r;
      chan_act_nxt = chan_act_r;
    end else begin
      cs_act_nxt = ctrl_nxt[`SAC_ADCS_HI:`SAC_ADCS_LO];
      chan_act_nxt = ctrl_nxt[`SAC_CHS_HI:`SAC_CHS_LO];
    end
  end

  // Reset restores selects to 11 and leaves the converter off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= SAC_IDLE;
      ctrl_r <= `SAC_CTRL_RESET;
      result_r <= `SAC_RESULT_RESET;
      marker_r <= 8'h00;
      tad_r <= 4'h0;
      div_r <= 4'h0;
      iosc_cnt_r <= 2'h0;
      cs_act_r <= `SAC_ADCS_IOSC;
      chan_act_r <= 2'h3;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      result_r <= result_nxt;
      marker_r <= marker_nxt;
      tad_r <= tad_nxt;
      div_r <= div_nxt;
      iosc_cnt_r <= iosc_cnt_nxt;
      cs_act_r <= cs_act_nxt;
      chan_act_r <= chan_act_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Front end outputs
  // ---------------------------------------------------------------
  // Pin decode ignores the power bit; comparator wiring is untouched outside
  always_comb begin
    case (ctrl_nxt[`SAC_ANS_HI:`SAC_ANS_LO])
      2'h0: pins_nxt = 3'b000;
      2'h1: pins_nxt = 3'b100;
      2'h2: pins_nxt = 3'b101;
      default: pins_nxt = 3'b111;
    endcase
  end

  // Channel route: 0..2 are pins, 3 is the internal reference
  assign chan_out_nxt = chan_act_nxt;
  assign sample_nxt = (state_nxt == SAC_CONV) && (tad_nxt <= `SAC_SAMPLE_LAST);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pins_r <= 3'b111;
      chan_out_r <= 2'h3;
      power_r <= 1'b0;
      sample_r <= 1'b0;
      dac_r <= `SAC_RESULT_RESET;
    end else begin
      pins_r <= pins_nxt;
      chan_out_r <= chan_out_nxt;
      power_r <= ctrl_nxt[`SAC_ON_BIT];
      sample_r <= sample_nxt;
      dac_r <= result_nxt;
    end
  end

  assign analog_pin_en = pins_r;
  assign adc_channel = chan_out_r;
  assign adc_power = power_r;
  assign sample_en = sample_r;
  assign dac_code = dac_r;

endmodule : sac_top

// ===== tb/sac_front_model.sv
// Analog front end model: channel levels, comparator and internal oscillator
`timescale 1ns/1ps
// ------
// Front end
// ------
module sac_front_model #(
  parameter logic [31:0] LEVELS = 32'h0
) (
  input wire sac_pkg::sac_field_t adc_channel,
  input wire sac_pkg::sac_byte_t dac_code,
  input wire logic adc_power,
  output logic cmp_result,
  output logic iosc_clk_in
);
  import sac_pkg::*;
  // Oscillator runs free, unrelated in phase to the system clock
  initial iosc_clk_in = 1'b0;
  always #13 iosc_clk_in = ~iosc_clk_in;
  // Input sits half a step above its code, so a tie never happens
  always_comb begin
    cmp_result = adc_power && ({LEVELS[adc_channel*8 +: 8], 1'b1} > {dac_code, 1'b0});
  end
endmodule : sac_front_model

// ===== tb/sac_top_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
// ------
// Bench
// ------
module sac_top_bench;
  import sac_pkg::*;
  localparam logic [31:0] LVLS = 32'hf0_01_c3_5a;
  // Rows: control written, control read back, pin enables
  localparam logic [18:0] ROWS [5] = '{{8'h01, 8'h01, 3'h0}, {8'h40, 8'h40, 3'h4},
    {8'h81, 8'h81, 3'h5}, {8'h02, 8'h00, 3'h0}, {8'hc1, 8'hc1, 3'h7}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  sac_addr_t avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic sleep_enter = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, iosc_clk_in, cmp_result, adc_power, sample_en;
  logic [2:0] analog_pin_en;
  sac_field_t adc_channel;
  sac_byte_t dac_code, rv, prev;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;
  sac_top u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_enter(sleep_enter),
    .iosc_clk_in(iosc_clk_in), .cmp_result(cmp_result), .analog_pin_en(analog_pin_en),
    .adc_channel(adc_channel), .adc_power(adc_power), .sample_en(sample_en),
    .dac_code(dac_code));
  sac_front_model #(.LEVELS(LVLS)) u_front (.adc_channel(adc_channel), .dac_code(dac_code),
    .adc_power(adc_power), .cmp_result(cmp_result), .iosc_clk_in(iosc_clk_in));
  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One bus cycle; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input sac_addr_t a, input sac_byte_t d,
                     output sac_byte_t q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    // Read data taken at the same edge; release only after it
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rdc(input sac_addr_t a, input sac_byte_t exp);
    bus(1'b0, a, 8'h0, rv);
    chk(rv, exp);
  endtask : rdc
  // Clock, cycle count and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(4'h0, 8'hfc);
    rdc(4'h4, 8'h00);
    chk(analog_pin_en, 3'h7);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 4'h0, ROWS[i][18:11], rv);
      rdc(4'h0, ROWS[i][10:3]);
      chk(analog_pin_en, ROWS[i][2:0]);
      chk(adc_power, ROWS[i][3]);
    end
    // Every clock and channel; selects changed mid-run must wait
    prev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h0, {2'h3, i[1:0], i[1:0], 2'h3}, rv);
      t0 = cyc;
      rdc(4'h4, prev);
      bus(1'b1, 4'h0, {2'h3, ~i[1:0], ~i[1:0], 2'h3}, rv);
      chk(adc_channel, i[1:0]);
      do bus(1'b0, 4'h0, 8'h0, rv); while (rv[1] === 1'b1);
      if (i < 3) begin
        chk((cyc - t0) >= 13 * (16 >> i) - 2 && (cyc - t0) <= 13 * (16 >> i) + 8, 1);
      end else begin
        // Oscillator mode: 52 counted rises of a 26 ns source plus sync lag
        chk((cyc - t0) >= 128 && (cyc - t0) <= 148, 1);
      end
      prev = LVLS[i*8 +: 8];
      rdc(4'h4, prev);
    end
    // Abort after three decided bits
    bus(1'b1, 4'h0, 8'hc3, rv);
    t0 = cyc;
    rdc(4'h0, 8'hc3);
    while (cyc != t0 + 132) @(posedge clk);
    bus(1'b1, 4'h0, 8'hc1, rv);
    rdc(4'h4, 8'h50);
    repeat (40) @(posedge clk);
    rdc(4'h4, 8'h50);
    // Sleep after one decided bit; pins are kept
    bus(1'b1, 4'h0, 8'h43, rv);
    repeat (100) @(posedge clk);
    sleep_enter <= 1'b1;
    @(posedge clk);
    sleep_enter <= 1'b0;
    rdc(4'h0, 8'h7c);
    rdc(4'h4, 8'h40);
    chk(analog_pin_en, 3'h4);
    // Refused writes and an unmapped read
    bus(1'b1, 4'h4, 8'h77, rv);
    rdc(4'h4, 8'h40);
    rdc(4'h8, 8'h00);
    avs_byteenable <= 4'h0;
    bus(1'b1, 4'h0, 8'h00, rv);
    avs_byteenable <= 4'h1;
    rdc(4'h0, 8'h7c);
    // Second reset while the converter is asleep and idle
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(4'h0, 8'hfc);
    rdc(4'h4, 8'h00);
    chk(analog_pin_en, 3'h7);
    chk(adc_power, 1'b0);
    tally_and_finish();
  end
endmodule : sac_top_bench

// ===== tb/sac_top_chk.sv
// Assertion checker bound to the converter control top
`timescale 1ns/1ps
// ------
// Checker
// ------
module sac_top_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire sac_pkg::sac_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic sleep_enter,
  input wire logic [2:0] analog_pin_en,
  input wire sac_pkg::sac_field_t adc_channel,
  input wire logic adc_power,
  input wire logic sample_en,
  input wire sac_pkg::sac_byte_t dac_code
);
  import sac_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic ctrl_wr;
  sac_byte_t wr_val;
  // Control writes taken; value kept since the bus moves on at once
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
  always_ff @(posedge clk) begin
    if (ctrl_wr) begin
      wr_val <= avs_writedata[7:0];
    end
  end
  // Pin enables of each select code
  function automatic logic [2:0] pins_of(input logic [1:0] s);
    return {s != 2'h0, s == 2'h3, s[1]};
  endfunction : pins_of
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  chk_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  chk_pin_sel: assert property (ctrl_wr |-> ##2 analog_pin_en == pins_of(wr_val[7:6]))
    else $error("pin enables do not match select");
  chk_power_bit: assert property (ctrl_wr |-> ##2 adc_power == wr_val[0])
    else $error("power output does not follow control");
  chk_go_refused: assert property (ctrl_wr && !avs_writedata[0] |-> ##2 !sample_en [*4])
    else $error("conversion started while powered off");
  chk_sample_hold: assert property (sample_en && $past(sample_en) |-> $stable(dac_code))
    else $error("result moved during sampling");
  chk_chan_held: assert property (sample_en && $past(sample_en) |-> $stable(adc_channel))
    else $error("channel moved during conversion");
  // A software abort may also end sampling; only a natural end loads the marker
  chk_marker_load: assert property ($fell(sample_en) && adc_power && !$past(ctrl_wr)
    |-> ##[0:2] dac_code == 8'h80)
    else $error("marker not loaded after sampling");
  chk_sleep_clear: assert property (sleep_enter |-> ##2 !adc_power && adc_channel == 2'h3)
    else $error("sleep did not clear power and channel");
  chk_reset_chan: assert property ($rose(rstn) |-> adc_channel == 2'h3 && !adc_power)
    else $error("channel not at reference after reset");
endmodule : sac_top_chk

bind sac_top sac_top_chk u_chk (
  .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .sleep_enter(sleep_enter),
  .analog_pin_en(analog_pin_en), .adc_channel(adc_channel), .adc_power(adc_power),
  .sample_en(sample_en), .dac_code(dac_code)
);
